// ===== duart_cfg.svh
`ifndef DUART_CFG_SVH
`define DUART_CFG_SVH
// ----------------------------------------
// Register offsets within a channel
// ----------------------------------------
`define DUART_OFS_DATA      3'h0
`define DUART_OFS_IEN       3'h1
`define DUART_OFS_IST       3'h2
`define DUART_OFS_LCTL      3'h3
`define DUART_OFS_MCTL      3'h4
`define DUART_OFS_LST       3'h5
`define DUART_OFS_MST       3'h6
`define DUART_OFS_SCR       3'h7
// ----------------------------------------
// Field positions and special values
// ----------------------------------------
`define DUART_LCTL_DIV_BIT   7
`define DUART_LCTL_ENH_KEY   8'hBF
`define DUART_EFEAT_ENH_BIT  4
`define DUART_MCTL_IRINV_BIT 2
// Masks of the extended bits, gated by the enhanced enable
`define DUART_IEN_EXT_MASK   8'hF0
`define DUART_IST_EXT_MASK   8'h30
`define DUART_QCTL_EXT_MASK  8'h30
`define DUART_MCTL_EXT_MASK  8'hE0
// Fraction register has two unused top bits
`define DUART_DIVFR_MASK     8'h3F
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DUART_RST_ZERO      8'h00
`define DUART_RST_LCTL      8'h00
`endif

// ===== duart_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host processor model on the register bus
// ----------------------------------------
module duart_host (
  input  wire logic                   mclk,
  output logic                        channel_a_select_n,
  output logic                        channel_b_select_n,
  output logic [2:0]                  addr,
  output logic                        wr_en,
  output logic                        rd_en,
  output duart_pkg::duart_byte_t      wr_data,
  input  wire duart_pkg::duart_byte_t rd_data
);
  import duart_pkg::*;

  // Idle bus until the first access
  initial begin
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    addr = 3'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
  end

  // One access: drive after an edge, hold through the taking edge
  task automatic acc(input logic [1:0] sel_n, input logic [2:0] a,
                     input logic w, input duart_byte_t d, output duart_byte_t q);
    @(posedge mclk);
    {channel_b_select_n, channel_a_select_n} <= sel_n;
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wr_data <= d;
    @(posedge mclk);
    {channel_b_select_n, channel_a_select_n} <= 2'b11;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // Released bus must not keep showing the old address and data
    addr <= ~a;
    wr_data <= ~d;
    #1 q = rd_data;
  endtask
endmodule // duart_host

// ===== duart_pkg.sv
package duart_pkg;
  // Byte wide register value
  typedef logic [7:0] duart_byte_t;
  // Register selected by the decoder for one access
  typedef enum {
    DUART_SEL_DATA, DUART_SEL_DIVLO, DUART_SEL_DIVHI, DUART_SEL_DIVFR, DUART_SEL_REV,
    DUART_SEL_DEV, DUART_SEL_IEN, DUART_SEL_IST, DUART_SEL_LCTL, DUART_SEL_MCTL,
    DUART_SEL_LST, DUART_SEL_MST, DUART_SEL_SCR, DUART_SEL_EFEAT, DUART_SEL_RES1,
    DUART_SEL_RES2, DUART_SEL_PAU1, DUART_SEL_PAU2
  } duart_sel_t;
endpackage

// ===== duart_regs.sv
`timescale 1ns/1ps
`include "duart_cfg.svh"
// Summary of operation
// - Two channels, each own registers, 3-bit address
// - Chip select routes access to one channel
// - Address 0 normal: read receive, write transmit
// - Divisor latch set: addresses 0,1 divisor bytes
// - Address 2 fraction divisor when divisor latch set, not key value, and enhanced enabled
// - Zero divisor with divisor latch set, not key value: address 0 reads revision code
// - Zero divisor with divisor latch set, not key value: address 1 reads device code
// - Address 1 normal: interrupt enable register
// - Address 2: read status, write queue control
// - Line control always at 3; modem at 4
// - Addresses 5,6 read line and modem status
// - Address 7 scratch register, no side effect
// - Key value opens enhanced feature at 2
// - Key value: flow characters at 4 to 7
// - Extended bits act only when enhanced enabled
// - Modem control bit 2 inverts infrared input
module duart_regs #(
  parameter int                  NUM_CH     = 2,     // Channel count
  parameter duart_pkg::duart_byte_t REV_CODE = 8'h01, // Revision, arbitrary value
  parameter duart_pkg::duart_byte_t DEV_CODE = 8'h5A  // Device code, arbitrary value
) (
  input  wire logic                   mclk,               // Host bus clock
  input  wire logic                   resetn,             // Synchronous reset
  input  wire logic                   channel_a_select_n, // Channel A select
  input  wire logic                   channel_b_select_n, // Channel B select
  input  wire logic [2:0]             addr,               // Register address
  input  wire logic                   wr_en,              // Write strobe
  input  wire logic                   rd_en,              // Read strobe
  input  wire duart_pkg::duart_byte_t wr_data,            // Write data
  input  wire duart_pkg::duart_byte_t rx_hold_a,          // Receive byte A
  input  wire duart_pkg::duart_byte_t rx_hold_b,          // Receive byte B
  input  wire duart_pkg::duart_byte_t int_stat_a,         // Interrupt status A
  input  wire duart_pkg::duart_byte_t int_stat_b,         // Interrupt status B
  input  wire duart_pkg::duart_byte_t line_stat_a,        // Line status A
  input  wire duart_pkg::duart_byte_t line_stat_b,        // Line status B
  input  wire duart_pkg::duart_byte_t modem_stat_a,       // Modem status A
  input  wire duart_pkg::duart_byte_t modem_stat_b,       // Modem status B
  input  wire logic                   ir_rx_a,            // Infrared input A pin
  input  wire logic                   ir_rx_b,            // Infrared input B pin
  output duart_pkg::duart_byte_t      rd_data,            // Read data
  output logic                        tx_load_a,          // Transmit write pulse A
  output logic                        tx_load_b,          // Transmit write pulse B
  output duart_pkg::duart_byte_t      tx_byte,            // Transmit byte
  output logic                        rx_read_a,          // Receive read pulse A
  output logic                        rx_read_b,          // Receive read pulse B
  output logic                        qctl_load_a,        // Queue control pulse A
  output logic                        qctl_load_b,        // Queue control pulse B
  output duart_pkg::duart_byte_t      qctl_byte,          // Queue control byte
  output logic                        ir_rx_dec_a,        // Corrected infrared A
  output logic                        ir_rx_dec_b         // Corrected infrared B
);
  import duart_pkg::*;

  initial begin
    if (NUM_CH != 2) $error("duart_regs serves exactly two channels");
  end

  // ----------------------------------------
  // Channel select and per-channel storage
  // ----------------------------------------
  // Exactly one select low picks a channel; both low is refused
  wire        sel_a = !channel_a_select_n && channel_b_select_n;
  wire        sel_b = !channel_b_select_n && channel_a_select_n;
  wire        any_sel = sel_a || sel_b;
  wire        ch = sel_b;                                       // Channel index

  // Per-channel registers, one array slot per channel
  duart_byte_t lctl_q  [NUM_CH];    // Line control
  duart_byte_t ien_q   [NUM_CH];    // Interrupt enable
  duart_byte_t divlo_q [NUM_CH];    // Baud divisor low byte
  duart_byte_t divhi_q [NUM_CH];    // Baud divisor high byte
  duart_byte_t divfr_q [NUM_CH];    // Baud divisor fraction
  duart_byte_t efeat_q [NUM_CH];    // Enhanced feature
  duart_byte_t mctl_q  [NUM_CH];    // Modem control
  duart_byte_t scr_q   [NUM_CH];    // Scratch, no effect on the channel
  duart_byte_t flow_q  [NUM_CH][4]; // Resume 1, resume 2, pause 1, pause 2

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Enhanced enable masks extended bits of a value
  function automatic duart_byte_t ext_gate(input duart_byte_t v, input duart_byte_t m,
                                           input logic en);
    ext_gate = en ? v : (v & ~m);
  endfunction

  // Channel B value when the B select won, else channel A
  function automatic duart_byte_t pick_ch(input logic b, input duart_byte_t va,
                                          input duart_byte_t vb);
    pick_ch = b ? vb : va;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // State of the selected channel that steers the address map
  wire duart_byte_t lctl_cur = lctl_q[ch];                      // Selected line control
  wire        lctl_div = lctl_cur[`DUART_LCTL_DIV_BIT];           // Divisor latch bit
  wire        key_open = (lctl_cur == `DUART_LCTL_ENH_KEY);
  wire        dlab     = lctl_div && !key_open;
  wire        enh_en   = efeat_q[ch][`DUART_EFEAT_ENH_BIT];
  wire        div_zero = (divlo_q[ch] == 8'h00) && (divhi_q[ch] == 8'h00);
  // Identification codes only in the plain divisor view, never behind the key
  wire        id_view  = dlab && div_zero;

  // Register selected by address and line control state
  // The key value has the divisor bit set, so 0 and 1 stay divisor bytes there
  duart_sel_t sel;
  always_comb begin
    sel = DUART_SEL_SCR;
    case (addr)
      `DUART_OFS_DATA: sel = lctl_div ? DUART_SEL_DIVLO : DUART_SEL_DATA;
      `DUART_OFS_IEN:  sel = lctl_div ? DUART_SEL_DIVHI : DUART_SEL_IEN;
      `DUART_OFS_IST:  sel = key_open ? DUART_SEL_EFEAT :
                             (dlab && enh_en) ? DUART_SEL_DIVFR :
                             DUART_SEL_IST;
      `DUART_OFS_LCTL: sel = DUART_SEL_LCTL;
      `DUART_OFS_MCTL: sel = key_open ? DUART_SEL_RES1 : DUART_SEL_MCTL;
      `DUART_OFS_LST:  sel = key_open ? DUART_SEL_RES2 : DUART_SEL_LST;
      `DUART_OFS_MST:  sel = key_open ? DUART_SEL_PAU1 : DUART_SEL_MST;
      `DUART_OFS_SCR:  sel = key_open ? DUART_SEL_PAU2 : DUART_SEL_SCR;
      default:         sel = DUART_SEL_SCR;
    endcase
  end

  // Read view: zero divisor swaps in identification codes
  // Write-only queue control has no readback; its address shows status
  duart_byte_t rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (sel)
      DUART_SEL_DATA:  rd_mux = pick_ch(ch, rx_hold_a, rx_hold_b);
      DUART_SEL_DIVLO: rd_mux = id_view ? REV_CODE : divlo_q[ch];
      DUART_SEL_DIVHI: rd_mux = id_view ? DEV_CODE : divhi_q[ch];
      DUART_SEL_DIVFR: rd_mux = divfr_q[ch];
      DUART_SEL_IEN:   rd_mux = ext_gate(ien_q[ch], `DUART_IEN_EXT_MASK, enh_en);
      DUART_SEL_IST:   rd_mux = ext_gate(pick_ch(ch, int_stat_a, int_stat_b),
                                         `DUART_IST_EXT_MASK, enh_en);
      DUART_SEL_LCTL:  rd_mux = lctl_cur;
      DUART_SEL_MCTL:  rd_mux = ext_gate(mctl_q[ch], `DUART_MCTL_EXT_MASK, enh_en);
      DUART_SEL_LST:   rd_mux = pick_ch(ch, line_stat_a, line_stat_b);
      DUART_SEL_MST:   rd_mux = pick_ch(ch, modem_stat_a, modem_stat_b);
      DUART_SEL_SCR:   rd_mux = scr_q[ch];
      DUART_SEL_EFEAT: rd_mux = efeat_q[ch];
      DUART_SEL_RES1:  rd_mux = flow_q[ch][0];
      DUART_SEL_RES2:  rd_mux = flow_q[ch][1];
      DUART_SEL_PAU1:  rd_mux = flow_q[ch][2];
      DUART_SEL_PAU2:  rd_mux = flow_q[ch][3];
      default:         rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  // Write and read take effect in a selected channel only
  wire wr_go   = wr_en && any_sel;
  wire rd_go   = rd_en && any_sel;
  // Datapath events decoded once and shared by the strobe flops
  wire data_wr = wr_go && (sel == DUART_SEL_DATA);
  wire data_rd = rd_go && (sel == DUART_SEL_DATA);
  wire qctl_wr = wr_go && (sel == DUART_SEL_IST);
  // Extended bits are dropped on write while the enhanced enable is off;
  // cheaper than storing them, but a later enable does not revive them
  wire duart_byte_t ien_wv  = ext_gate(wr_data, `DUART_IEN_EXT_MASK, enh_en);
  wire duart_byte_t mctl_wv = ext_gate(wr_data, `DUART_MCTL_EXT_MASK, enh_en);
  wire duart_byte_t qctl_wv = ext_gate(wr_data, `DUART_QCTL_EXT_MASK, enh_en);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Status selections have no storage so writes there fall away
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // All channels cleared together
      for (int i = 0; i < NUM_CH; i++) begin
        lctl_q[i]  <= `DUART_RST_LCTL;
        ien_q[i]   <= `DUART_RST_ZERO;
        divlo_q[i] <= `DUART_RST_ZERO;
        divhi_q[i] <= `DUART_RST_ZERO;
        divfr_q[i] <= `DUART_RST_ZERO;
        efeat_q[i] <= `DUART_RST_ZERO;
        mctl_q[i]  <= `DUART_RST_ZERO;
        scr_q[i]   <= `DUART_RST_ZERO;
        for (int j = 0; j < 4; j++) flow_q[i][j] <= `DUART_RST_ZERO;
      end
    end else if (wr_go) begin
      // Only the selected channel's slot is touched
      case (sel)
        DUART_SEL_LCTL:  lctl_q[ch]    <= wr_data;
        DUART_SEL_IEN:   ien_q[ch]     <= ien_wv;
        DUART_SEL_DIVLO: divlo_q[ch]   <= wr_data;
        DUART_SEL_DIVHI: divhi_q[ch]   <= wr_data;
        DUART_SEL_DIVFR: divfr_q[ch]   <= wr_data & `DUART_DIVFR_MASK;
        DUART_SEL_EFEAT: efeat_q[ch]   <= wr_data;
        DUART_SEL_MCTL:  mctl_q[ch]    <= mctl_wv;
        DUART_SEL_SCR:   scr_q[ch]     <= wr_data;
        DUART_SEL_RES1:  flow_q[ch][0] <= wr_data;
        DUART_SEL_RES2:  flow_q[ch][1] <= wr_data;
        DUART_SEL_PAU1:  flow_q[ch][2] <= wr_data;
        DUART_SEL_PAU2:  flow_q[ch][3] <= wr_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs and strobes
  // ----------------------------------------
  // Read data and pulses land one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_data     <= 8'h00;
      tx_load_a   <= 1'b0;
      tx_load_b   <= 1'b0;
      rx_read_a   <= 1'b0;
      rx_read_b   <= 1'b0;
      qctl_load_a <= 1'b0;
      qctl_load_b <= 1'b0;
      tx_byte     <= 8'h00;
      qctl_byte   <= 8'h00;
    end else begin
      // Idle bus reads as zero, so a stale byte never lingers
      rd_data     <= rd_go ? rd_mux : 8'h00;
      tx_load_a   <= data_wr && !ch;
      tx_load_b   <= data_wr && ch;
      rx_read_a   <= data_rd && !ch;
      rx_read_b   <= data_rd && ch;
      qctl_load_a <= qctl_wr && !ch;
      qctl_load_b <= qctl_wr && ch;
      // Bytes hold until the next load of their kind
      if (data_wr) tx_byte <= wr_data;
      if (qctl_wr) qctl_byte <= qctl_wv;
    end
  end

  // ----------------------------------------
  // Infrared input polarity
  // ----------------------------------------
  // Pins are asynchronous, so two flops before the invert
  logic [1:0] ira_sync_q;  // Channel A synchroniser
  logic [1:0] irb_sync_q;  // Channel B synchroniser
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ira_sync_q  <= 2'b00;
      irb_sync_q  <= 2'b00;
      ir_rx_dec_a <= 1'b0;
      ir_rx_dec_b <= 1'b0;
    end else begin
      ira_sync_q  <= {ira_sync_q[0], ir_rx_a};
      irb_sync_q  <= {irb_sync_q[0], ir_rx_b};
      ir_rx_dec_a <= ira_sync_q[1] ^ mctl_q[0][`DUART_MCTL_IRINV_BIT];
      ir_rx_dec_b <= irb_sync_q[1] ^ mctl_q[1][`DUART_MCTL_IRINV_BIT];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Line control is reachable whatever its value
  a_lctl_always_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_go && addr == `DUART_OFS_LCTL |=> lctl_q[$past(ch)] == $past(wr_data))
    else $error("line control write lost");
  // Transmit load only from the plain data view
  a_tx_only_normal: assert property (@(posedge mclk) disable iff (!resetn)
    (tx_load_a || tx_load_b) |-> $past(addr) == `DUART_OFS_DATA
    && !$past(lctl_div))
    else $error("transmit load at wrong selection");
  // Both selects low must not reach either channel
  a_no_dual_sel: assert property (@(posedge mclk) disable iff (!resetn)
    !channel_a_select_n && !channel_b_select_n && wr_en
    |=> !tx_load_a && !tx_load_b && !qctl_load_a && !qctl_load_b)
    else $error("write taken with both selects");
  // Unselected reads return zero
  a_no_sel_read: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en && !any_sel |=> rd_data == 8'h00)
    else $error("read answered without a select");
  a_rev_zero_div: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && addr == `DUART_OFS_DATA && dlab && div_zero |=> rd_data == REV_CODE)
    else $error("revision code not returned");
  a_dev_zero_div: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && addr == `DUART_OFS_IEN && dlab && div_zero |=> rd_data == DEV_CODE)
    else $error("device code not returned");
  // Behind the key the divisor low byte shows, never the revision
  a_key_div_plain: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && addr == `DUART_OFS_DATA && key_open |=> rd_data == $past(divlo_q[ch]))
    else $error("identification shown behind key");
  a_efeat_key: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && addr == `DUART_OFS_IST && key_open |=> rd_data == $past(efeat_q[ch]))
    else $error("enhanced feature not at key");
  // Fraction keeps only its six low bits
  a_frac_mask: assert property (@(posedge mclk) disable iff (!resetn)
    wr_go && sel == DUART_SEL_DIVFR
    |=> divfr_q[$past(ch)] == ($past(wr_data) & `DUART_DIVFR_MASK))
    else $error("fraction write wrong");
  a_ien_ext_gate: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && sel == DUART_SEL_IEN && !enh_en |=> rd_data[7:4] == 4'h0)
    else $error("extended enable bits leak");
  a_ir_invert: assert property (@(posedge mclk) disable iff (!resetn)
    ##3 ir_rx_dec_a == ($past(ir_rx_a, 3) ^ $past(mctl_q[0][`DUART_MCTL_IRINV_BIT])))
    else $error("infrared polarity wrong");
  a_status_ro: assert property (@(posedge mclk) disable iff (!resetn)
    wr_go && sel == DUART_SEL_LST |=> $stable(scr_q[0]) && $stable(scr_q[1]))
    else $error("status write disturbed scratch");
  // A channel A write leaves channel B untouched
  a_scr_chan_iso: assert property (@(posedge mclk) disable iff (!resetn)
    wr_go && sel == DUART_SEL_SCR && !ch |=> $stable(scr_q[1]))
    else $error("channel write leaked across");
  c_key_open:    cover property (@(posedge mclk) wr_go && key_open && sel == DUART_SEL_PAU2);
  c_frac_wr:     cover property (@(posedge mclk) wr_go && sel == DUART_SEL_DIVFR);
  c_chan_b_tx:   cover property (@(posedge mclk) tx_load_b);
  c_id_read:     cover property (@(posedge mclk) rd_go && id_view && addr == `DUART_OFS_DATA);
  c_chan_b_qctl: cover property (@(posedge mclk) qctl_load_b);
endmodule // duart_regs

// ===== tb_duart_regs.sv
`timescale 1ns/1ps
module tb_duart_regs;
  import duart_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam duart_byte_t REV = 8'h3C; // Arbitrary value
  localparam duart_byte_t DEV = 8'hC3; // Arbitrary value
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        channel_a_select_n, channel_b_select_n, wr_en, rd_en;
  logic [2:0]  addr;
  duart_byte_t wr_data, rd_data, tx_byte, qctl_byte, q;
  duart_byte_t rx_hold_a = 8'hA1, rx_hold_b = 8'hB2;   // Distinct per channel
  duart_byte_t int_stat_a = 8'hFF, int_stat_b = 8'hFF; // Extended bits set
  duart_byte_t line_stat_a = 8'h61, line_stat_b = 8'h62;
  duart_byte_t modem_stat_a = 8'h71, modem_stat_b = 8'h72;
  logic        ir_rx_a = 1'b0, ir_rx_b = 1'b0;
  logic        tx_load_a, tx_load_b, rx_read_a, rx_read_b;
  logic        qctl_load_a, qctl_load_b, ir_rx_dec_a, ir_rx_dec_b;
  int          checks = 0;
  int          bad_count = 0;

  // 50 ns clock
  always #25 mclk = ~mclk;

  duart_host duart_host_i (.mclk(mclk), .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data));

  duart_regs #(.NUM_CH(2), .REV_CODE(REV), .DEV_CODE(DEV)) duart_regs_i (
    .mclk(mclk), .resetn(resetn), .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .rx_hold_a(rx_hold_a), .rx_hold_b(rx_hold_b),
    .int_stat_a(int_stat_a), .int_stat_b(int_stat_b), .line_stat_a(line_stat_a),
    .line_stat_b(line_stat_b), .modem_stat_a(modem_stat_a),
    .modem_stat_b(modem_stat_b), .ir_rx_a(ir_rx_a), .ir_rx_b(ir_rx_b),
    .rd_data(rd_data), .tx_load_a(tx_load_a), .tx_load_b(tx_load_b),
    .tx_byte(tx_byte), .rx_read_a(rx_read_a), .rx_read_b(rx_read_b),
    .qctl_load_a(qctl_load_a), .qctl_load_b(qctl_load_b), .qctl_byte(qctl_byte),
    .ir_rx_dec_a(ir_rx_dec_a), .ir_rx_dec_b(ir_rx_dec_b));

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk(input duart_byte_t got, input duart_byte_t exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Channel 0 is A, 1 is B; selects are active low
  task automatic wr(input int ch, input logic [2:0] a, input duart_byte_t d);
    duart_host_i.acc(ch ? 2'b01 : 2'b10, a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input int ch, input logic [2:0] a, input duart_byte_t exp);
    duart_host_i.acc(ch ? 2'b01 : 2'b10, a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 135 cycles the tests need
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    end_sim;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      rd_chk(c, 3'h3, 8'h00);
      rd_chk(c, 3'h1, 8'h00);
      rd_chk(c, 3'h7, 8'h00);
    end
    $display("test reset done");
    // Independent channels; a double select must be ignored
    wr(0, 3'h7, 8'h11);
    wr(1, 3'h7, 8'h22);
    duart_host_i.acc(2'b00, 3'h7, 1'b1, 8'h99, q);
    duart_host_i.acc(2'b00, 3'h0, 1'b0, 8'h00, q);
    chk1(rx_read_a, 1'b0);
    rd_chk(0, 3'h7, 8'h11);
    rd_chk(1, 3'h7, 8'h22);
    for (int c = 0; c < 2; c++) begin
      rd_chk(c, 3'h0, c ? rx_hold_b : rx_hold_a);
      chk1(c ? rx_read_b : rx_read_a, 1'b1);
      chk1(c ? rx_read_a : rx_read_b, 1'b0);
      wr(c, 3'h0, 8'h5C);
      chk1(c ? tx_load_b : tx_load_a, 1'b1);
      chk(tx_byte, 8'h5C);
    end
    $display("test channels done");
    // Divisor latch with identification at zero divisor
    wr(0, 3'h3, 8'h80);
    rd_chk(0, 3'h0, REV);
    rd_chk(0, 3'h1, DEV);
    wr(0, 3'h0, 8'h34);
    chk1(tx_load_a, 1'b0);
    rd_chk(0, 3'h0, 8'h34);
    rd_chk(0, 3'h1, 8'h00);
    wr(0, 3'h1, 8'h12);
    rd_chk(0, 3'h1, 8'h12);
    rd_chk(0, 3'h2, 8'hCF);
    $display("test divisor done");
    // Enhanced bank behind the key value
    wr(0, 3'h3, 8'hBF);
    rd_chk(0, 3'h3, 8'hBF);
    wr(0, 3'h2, 8'h10);
    rd_chk(0, 3'h2, 8'h10);
    for (int i = 4; i < 8; i++) wr(0, i[2:0], duart_byte_t'(8'hA0 + i));
    for (int i = 4; i < 8; i++) rd_chk(0, i[2:0], duart_byte_t'(8'hA0 + i));
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h2, 8'hFF);
    chk1(qctl_load_a, 1'b0);
    rd_chk(0, 3'h2, 8'h3F);
    wr(0, 3'h3, 8'h03);
    rd_chk(0, 3'h4, 8'h00);
    rd_chk(0, 3'h7, 8'h11);
    rd_chk(0, 3'h2, 8'hFF);
    chk1(qctl_load_a, 1'b0);
    wr(0, 3'h2, 8'hFF);
    chk1(qctl_load_a, 1'b1);
    chk(qctl_byte, 8'hFF);
    wr(0, 3'h1, 8'hFF);
    rd_chk(0, 3'h1, 8'hFF);
    wr(0, 3'h4, 8'hFF);
    rd_chk(0, 3'h4, 8'hFF);
    wr(0, 3'h5, 8'h00);
    rd_chk(0, 3'h5, line_stat_a);
    rd_chk(0, 3'h6, modem_stat_a);
    $display("test enhanced done");
    // Key value on B: zero divisor still reads as divisor bytes
    wr(1, 3'h3, 8'hBF);
    rd_chk(1, 3'h0, 8'h00);
    rd_chk(1, 3'h1, 8'h00);
    wr(1, 3'h3, 8'h00);
    // Channel B keeps the enhanced bits off
    wr(1, 3'h1, 8'hFF);
    rd_chk(1, 3'h1, 8'h0F);
    wr(1, 3'h4, 8'hFB);
    rd_chk(1, 3'h4, 8'h1B);
    wr(1, 3'h2, 8'hFF);
    chk1(qctl_load_b, 1'b1);
    chk(qctl_byte, 8'hCF);
    // Infrared input polarity: A inverted, B straight
    @(posedge mclk);
    ir_rx_a <= 1'b1;
    ir_rx_b <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk1(ir_rx_dec_a, 1'b0);
    chk1(ir_rx_dec_b, 1'b1);
    $display("test channel b done");
    end_sim;
  end
endmodule // tb_duart_regs
